// File: core/rscr_event_latch.sv
// Purpose: sticky event flags, cleared by a read of the flag register
// Assumes: one clock, synchronous active-high reset
// Notes: a set arriving with the clear stays latched
`timescale 1ns/1ns
module rscr_event_latch #(
    parameter int unsigned WIDTH = 6,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic clear_in,
    output logic [WIDTH-1:0] flags_out
);
    // refuse a width the flag vector cannot hold
    if (WIDTH < 1) begin : g_bad_width
        $error("rscr_event_latch: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] flags_d;

    // set wins over the read clear
    assign flags_d = (clear_in ? '0 : flags_out) | set_in;

    // sticky flag storage
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            flags_out <= RESET_VALUE;
        end else begin
            flags_out <= flags_d;
        end
    end
endmodule : rscr_event_latch

// File: core/rscr_pkg.sv
// Purpose: constants for the regulator status and auxiliary control bank
// Assumes: 8-bit register data, 3-bit register address
// Notes: offsets, field positions and reset values live here; the checks and the bench repeat them as literals
package rscr_pkg;
    localparam int unsigned RSCR_DATA_W = 8;
    localparam int unsigned RSCR_ADDR_W = 3;
    localparam int unsigned RSCR_NUM_EVENTS = 6;
    // register addresses
    localparam logic [2:0] RSCR_AUX_CONTROL_ADDR = 3'h3;
    localparam logic [2:0] RSCR_EVENT_FLAGS_ADDR = 3'h4;
    // reset values
    localparam logic [7:0] RSCR_AUX_CONTROL_RST = 8'h00;
    localparam logic [5:0] RSCR_EVENT_FLAGS_RST = 6'h02;
    // aux_control fields
    localparam int unsigned RSCR_STANDALONE_BIT = 1;
    localparam int unsigned RSCR_GOOD_BLANK_BIT = 0;
    localparam logic [7:0] RSCR_AUX_WRITE_MASK = 8'h03;
    // event_flags fields
    localparam int unsigned RSCR_RETRY_BIT = 5;
    localparam int unsigned RSCR_CURRENT_LIMIT_BIT = 4;
    localparam int unsigned RSCR_THERMAL_WARNING_BIT = 3;
    localparam int unsigned RSCR_THERMAL_SHUTDOWN_BIT = 2;
    localparam int unsigned RSCR_UNDERVOLTAGE_BIT = 1;
    localparam int unsigned RSCR_OVERVOLTAGE_BIT = 0;
endpackage : rscr_pkg

// File: core/rscr_regs.sv
// Purpose: auxiliary control and sticky event-flag registers of a regulator
// Assumes: register port is synchronous to clk_sys_in, one access per cycle
// Notes: read data is registered, one cycle after the read strobe
`timescale 1ns/1ns

// Overview of operation
// - standalone bit set turns off enable pulldown and sync output
// - blanking clear makes power-good follow the window comparator
// - blanking set floats power-good during an output-voltage transition
// - aux control bits 7 to 2 reserved, reset zero, written zero
// - event flag bits 7 to 6 reserved and read as zero
// - retry flag bit 5 set on hiccup, held until read
// - current-limit flag bit 4 set on event, held until read
// - thermal-warning flag bit 3 set on event, held until read
// - thermal-shutdown flag bit 2 set on event, held until read
// - undervoltage flag bit 1 set when output low, held until read
// - overvoltage flag bit 0 set when output high, held until read
// - event flags read-only at address 4h, reset value 2h
// - aux control at address 3h, reset 0h
module rscr_regs
    import rscr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [rscr_pkg::RSCR_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [rscr_pkg::RSCR_DATA_W-1:0] reg_wdata_in,
    output logic [rscr_pkg::RSCR_DATA_W-1:0] reg_rdata_out,
    input wire logic hiccup_event_in,
    input wire logic current_limit_event_in,
    input wire logic thermal_warning_event_in,
    input wire logic thermal_shutdown_event_in,
    input wire logic undervoltage_event_in,
    input wire logic overvoltage_event_in,
    input wire logic window_comparator_in,
    input wire logic voltage_transition_in,
    output logic power_good_output_out,
    output logic power_good_output_oe_out,
    output logic enable_pulldown_out,
    output logic sync_clock_enable_out
);
    import rscr_pkg::*;

    logic [7:0] aux_control_q;
    logic [7:0] aux_control_d;
    logic [5:0] event_flags;
    logic [5:0] event_set;
    logic hit_aux;
    logic hit_flags;
    logic flags_read;
    logic standalone;
    logic good_blank_on_ramp;
    logic good_float;
    logic [7:0] rdata_d;

    // address decode
    assign hit_aux = (reg_addr_in == RSCR_AUX_CONTROL_ADDR);
    assign hit_flags = (reg_addr_in == RSCR_EVENT_FLAGS_ADDR);
    assign flags_read = reg_rd_in && hit_flags;

    // control write, reserved bits forced to zero
    assign aux_control_d = (reg_wr_in && hit_aux) ?
        (reg_wdata_in & RSCR_AUX_WRITE_MASK) : aux_control_q;

    assign standalone = aux_control_q[RSCR_STANDALONE_BIT];
    assign good_blank_on_ramp = aux_control_q[RSCR_GOOD_BLANK_BIT];
    assign good_float = good_blank_on_ramp && voltage_transition_in;

    // event set vector in flag bit order
    assign event_set[RSCR_RETRY_BIT] = hiccup_event_in;
    assign event_set[RSCR_CURRENT_LIMIT_BIT] = current_limit_event_in;
    assign event_set[RSCR_THERMAL_WARNING_BIT] =
        thermal_warning_event_in;
    assign event_set[RSCR_THERMAL_SHUTDOWN_BIT] =
        thermal_shutdown_event_in;
    assign event_set[RSCR_UNDERVOLTAGE_BIT] = undervoltage_event_in;
    assign event_set[RSCR_OVERVOLTAGE_BIT] = overvoltage_event_in;

    // read mux, unmapped addresses read zero
    assign rdata_d = hit_aux ? aux_control_q :
        hit_flags ? {2'h0, event_flags} : 8'h00;

    rscr_event_latch #(
        .WIDTH(RSCR_NUM_EVENTS),
        .RESET_VALUE(RSCR_EVENT_FLAGS_RST)
    ) u_flags (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .set_in(event_set),
        .clear_in(flags_read),
        .flags_out(event_flags)
    );

    // control register and read data
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            aux_control_q <= RSCR_AUX_CONTROL_RST;
            reg_rdata_out <= 8'h00;
        end else begin
            aux_control_q <= aux_control_d;
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_d;
            end
        end
    end

    // pin-side outputs, registered
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            power_good_output_out <= 1'b0;
            power_good_output_oe_out <= 1'b0;
            enable_pulldown_out <= 1'b1;
            sync_clock_enable_out <= 1'b1;
        end else begin
            // open-drain: drive low when not good and not blanked, float otherwise
            power_good_output_out <= 1'b0;
            power_good_output_oe_out <=
                !window_comparator_in && !good_float;
            enable_pulldown_out <= !standalone;
            sync_clock_enable_out <= !standalone;
        end
    end

    // checks
    property p_standalone_gates;
        @(posedge clk_sys_in) disable iff (srst_in)
        aux_control_q[1] |=> (!enable_pulldown_out && !sync_clock_enable_out);
    endproperty
    a_standalone_gates: assert property (p_standalone_gates)
        else $error("standalone did not gate pulldown and sync");

    property p_good_follows;
        @(posedge clk_sys_in) disable iff (srst_in)
        !aux_control_q[0] |=> (power_good_output_oe_out ==
            !$past(window_comparator_in));
    endproperty
    a_good_follows: assert property (p_good_follows)
        else $error("power good does not follow comparator");

    property p_good_blank;
        @(posedge clk_sys_in) disable iff (srst_in)
        (aux_control_q[0] && voltage_transition_in) |=>
            !power_good_output_oe_out;
    endproperty
    a_good_blank: assert property (p_good_blank)
        else $error("power good driven during blanked transition");

    property p_aux_reserved;
        @(posedge clk_sys_in) disable iff (srst_in)
        aux_control_q[7:2] == 6'h00;
    endproperty
    a_aux_reserved: assert property (p_aux_reserved)
        else $error("aux control reserved bits nonzero");

    property p_flags_reserved;
        @(posedge clk_sys_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == 3'h4) |=> reg_rdata_out[7:6] == 2'h0;
    endproperty
    a_flags_reserved: assert property (p_flags_reserved)
        else $error("event flag reserved bits nonzero");

    property p_event_sticks;
        @(posedge clk_sys_in) disable iff (srst_in)
        (hiccup_event_in ##1 !(reg_rd_in && reg_addr_in == 3'h4)[*2])
            |-> event_flags[5];
    endproperty
    a_event_sticks: assert property (p_event_sticks)
        else $error("retry flag lost before read");

    property p_read_clears;
        @(posedge clk_sys_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == 3'h4 && !current_limit_event_in)
            |=> !event_flags[4] && reg_rdata_out[4] == $past(event_flags[4]);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flag read did not return then clear");

    property p_set_wins;
        @(posedge clk_sys_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == 3'h4 && overvoltage_event_in)
            |=> event_flags[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost on clear cycle");

    property p_reset_values;
        @(posedge clk_sys_in)
        $fell(srst_in) |-> (event_flags == 6'h02 && aux_control_q == 8'h00);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("wrong reset values");

    property p_aux_write;
        @(posedge clk_sys_in) disable iff (srst_in)
        (reg_wr_in && reg_addr_in == 3'h3) |=>
            aux_control_q == {6'h00, $past(reg_wdata_in[1:0])};
    endproperty
    a_aux_write: assert property (p_aux_write)
        else $error("aux control write not stored with reserved bits zero");

    property p_limit_sticks;
        @(posedge clk_sys_in) disable iff (srst_in)
        (current_limit_event_in ##1
            !(reg_rd_in && reg_addr_in == 3'h4)[*2]) |-> event_flags[4];
    endproperty
    a_limit_sticks: assert property (p_limit_sticks)
        else $error("current limit flag lost before read");

    property p_warning_sticks;
        @(posedge clk_sys_in) disable iff (srst_in)
        (thermal_warning_event_in ##1
            !(reg_rd_in && reg_addr_in == 3'h4)[*2]) |-> event_flags[3];
    endproperty
    a_warning_sticks: assert property (p_warning_sticks)
        else $error("thermal warning flag lost before read");

    property p_shutdown_sticks;
        @(posedge clk_sys_in) disable iff (srst_in)
        (thermal_shutdown_event_in ##1
            !(reg_rd_in && reg_addr_in == 3'h4)[*2]) |-> event_flags[2];
    endproperty
    a_shutdown_sticks: assert property (p_shutdown_sticks)
        else $error("thermal shutdown flag lost before read");

    property p_under_sticks;
        @(posedge clk_sys_in) disable iff (srst_in)
        (undervoltage_event_in ##1
            !(reg_rd_in && reg_addr_in == 3'h4)[*2]) |-> event_flags[1];
    endproperty
    a_under_sticks: assert property (p_under_sticks)
        else $error("undervoltage flag lost before read");
endmodule : rscr_regs

// File: test/rscr_host_model.sv
// Purpose: register host that issues single-byte strobed accesses
// Assumes: strobes sampled on the rising edge, read data one cycle later
// Notes: released address and write data are inverted, never left stale
`timescale 1ns/1ns
module rscr_host_model
    import rscr_pkg::*;
#(
    parameter bit STACKED = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic [rscr_pkg::RSCR_DATA_W-1:0] rdata_in,
    output logic [rscr_pkg::RSCR_ADDR_W-1:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [rscr_pkg::RSCR_DATA_W-1:0] wdata_out
);
    import rscr_pkg::*;
    // stacked hosts never set the standalone bit through wr; wr_raw sends it as given
    localparam logic [7:0] AUX_MASK = STACKED ? 8'h01 : RSCR_AUX_WRITE_MASK;
    // idle bus at time zero
    initial begin
        addr_out = 3'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // one write strobe, data sent exactly as given
    task automatic wr_raw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : wr_raw
    // one write strobe, aux control reserved bits sent as zero, other addresses sent as given
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        if (a == RSCR_AUX_CONTROL_ADDR) begin
            wr_raw(a, d & AUX_MASK);
        end else begin
            wr_raw(a, d);
        end
    endtask : wr
    // one read strobe, data taken after the answering edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in; // top bits carry no meaning for the host
    endtask : rd
endmodule : rscr_host_model

// File: test/tb.sv
// Purpose: self-checking bench for the regulator register bank
// Assumes: read data one cycle after the strobe, pins one cycle after aux
// Notes: all register traffic goes through the host model
`timescale 1ns/1ns
module tb;
    import rscr_pkg::*;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [5:0] ev = 6'h00;
    logic win = 1'b0;
    logic trans = 1'b0;
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic good_pin;
    logic good_oe;
    logic pd;
    logic sync;
    int fail_count = 0;
    int check_count = 0;
    // free-running system clock
    always #2 clk_sys_in = ~clk_sys_in;
    rscr_regs rscr_regs_i (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .hiccup_event_in(ev[5]), .current_limit_event_in(ev[4]),
        .thermal_warning_event_in(ev[3]), .thermal_shutdown_event_in(ev[2]),
        .undervoltage_event_in(ev[1]), .overvoltage_event_in(ev[0]),
        .window_comparator_in(win), .voltage_transition_in(trans),
        .power_good_output_out(good_pin), .power_good_output_oe_out(good_oe),
        .enable_pulldown_out(pd), .sync_clock_enable_out(sync));
    rscr_host_model rscr_host_model_i (.clk_sys_in(clk_sys_in),
        .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rscr_host_model_i.rd(a, d);
        check(d, exp);
    endtask : rdchk
    // apply comparator inputs, then compare {good, oe, pulldown, sync}
    task automatic pins(input logic w, input logic t, input logic [3:0] exp);
        @(posedge clk_sys_in);
        win <= w;
        trans <= t;
        @(posedge clk_sys_in);
        @(posedge clk_sys_in);
        #1;
        check({4'h0, good_pin, good_oe, pd, sync}, {4'h0, exp});
    endtask : pins
    task automatic final_report;
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        pins(1'b0, 1'b1, 4'b0111);
        rdchk(3'h3, 8'h00);
        rdchk(3'h4, 8'h02);
        rdchk(3'h4, 8'h00);
        rdchk(3'h7, 8'h00);
        rscr_host_model_i.wr(3'h4, 8'h3F);
        rdchk(3'h4, 8'h00);
        rscr_host_model_i.wr(3'h3, 8'h03);
        rdchk(3'h3, 8'h03);
        // reserved bits written as ones must not stick
        rscr_host_model_i.wr_raw(3'h3, 8'hFF);
        rdchk(3'h3, 8'h03);
        pins(1'b0, 1'b0, 4'b0100);
        pins(1'b0, 1'b1, 4'b0000);
        rscr_host_model_i.wr(3'h3, 8'h00);
        pins(1'b0, 1'b1, 4'b0111);
        pins(1'b1, 1'b1, 4'b0011);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            ev <= 6'h01 << i;
            @(posedge clk_sys_in);
            ev <= 6'h00;
            repeat (2) @(posedge clk_sys_in);
            rdchk(3'h4, 8'h01 << i);
            rdchk(3'h4, 8'h00);
        end
        // event landing on the clearing read survives
        fork
            rdchk(3'h4, 8'h00);
            begin
                @(posedge clk_sys_in);
                ev <= 6'h20;
                @(posedge clk_sys_in);
                ev <= 6'h00;
            end
        join
        rdchk(3'h4, 8'h20);
        // second reset after the bank has been changed
        rscr_host_model_i.wr(3'h3, 8'h03);
        @(posedge clk_sys_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        rdchk(3'h3, 8'h00);
        rdchk(3'h4, 8'h02);
        pins(1'b0, 1'b0, 4'b0111);
        final_report();
    end
endmodule : tb
